// file: hdl/pulse_width_unit.sv
// six-channel pulse width unit: registers, duty counters, cascading and pins.
// assumes a synchronous byte-wide register port and pins feeding a filter.
`timescale 1ns/1ps
`include "pwm_consts.svh"
module pulse_width_unit #(
	parameter int CHANNELS = 6
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire pwm_pkg::reg_req_s regReq,
	output logic [7:0] rdData,
	output logic [CHANNELS-1:0] pwmOut
);
	localparam int PAIRS = CHANNELS / 2;

	generate
		if (CHANNELS < 2 || CHANNELS > 8 || CHANNELS % 2 != 0) begin : gen_bad_channels
			$error("CHANNELS must be even and between 2 and 8");
		end
	endgenerate

	// software-visible settings
	logic [7:0] prescaleSetting [CHANNELS];
	logic [7:0] dutySetting [CHANNELS];
	logic [CHANNELS-1:0] channelOutputEnable;
	logic [CHANNELS-1:0] addedPulsePolarity;
	logic [2*PAIRS-1:0] pairMode;
	logic [CHANNELS-1:0] divisionSelect;
	logic moduleStop;

	// working state
	logic [7:0] dutyLatch [CHANNELS];
	logic [15:0] dutyCount [CHANNELS];
	logic [CHANNELS-1:0] run;
	logic [CHANNELS-1:0] tick;
	logic [CHANNELS-1:0] overflow;
	logic [CHANNELS-1:0] divLevel;
	pwm_pkg::chan_mode_e chanMode [CHANNELS];

	logic wrAccess;
	logic rdAccess;
	logic [7:0] next_rdData;

	// register window decode: true when addr hits an existing channel of the block
	function automatic logic inBlock(input logic [7:0] addr, input logic [7:0] base);
		return (addr & `PWM_ADDR_BLOCK_MASK) == base && 32'(addr[2:0]) < CHANNELS;
	endfunction

	function automatic logic [15:0] limitFor(input pwm_pkg::chan_mode_e mode);
		case (mode)
			pwm_pkg::MODE_SINGLE12: limitFor = `PWM_LIMIT_SINGLE12;
			pwm_pkg::MODE_SINGLE16: limitFor = `PWM_LIMIT_SINGLE16;
			pwm_pkg::MODE_DIV8: limitFor = `PWM_LIMIT_DIV8;
			default: limitFor = `PWM_LIMIT_SINGLE8;
		endcase
	endfunction

	// while stopped only the module stop register answers
	assign wrAccess = regReq.wrStrobe && !moduleStop;
	assign rdAccess = regReq.rdStrobe && !moduleStop;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			moduleStop <= `PWM_RESET_MODULE_STOP;
		end else if (regReq.wrStrobe && regReq.addr == `PWM_ADDR_MODULE_STOP) begin
			moduleStop <= regReq.wrData[0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			channelOutputEnable <= '0;
		end else if (wrAccess && regReq.addr == `PWM_ADDR_OUTPUT_CONTROL) begin
			channelOutputEnable <= regReq.wrData[CHANNELS-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			addedPulsePolarity <= '0;
		end else if (wrAccess && regReq.addr == `PWM_ADDR_POLARITY) begin
			addedPulsePolarity <= regReq.wrData[CHANNELS-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pairMode <= '0;
		end else if (wrAccess && regReq.addr == `PWM_ADDR_PAIR_MODE) begin
			pairMode <= regReq.wrData[2*PAIRS-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			divisionSelect <= '0;
		end else if (wrAccess && regReq.addr == `PWM_ADDR_DIVISION_SELECT) begin
			divisionSelect <= regReq.wrData[CHANNELS-1:0];
		end
	end

	// wide duty values arrive as two single-byte writes; the pair only takes
	// them at the next joint overflow, so a half-written value can show for at
	// most one period if the high byte is written late
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < CHANNELS; i++) begin
				prescaleSetting[i] <= `PWM_RESET_BYTE;
				dutySetting[i] <= `PWM_RESET_BYTE;
			end
		end else if (wrAccess) begin
			if (inBlock(regReq.addr, `PWM_ADDR_PRESCALE_BASE)) begin
				prescaleSetting[regReq.addr[2:0]] <= regReq.wrData;
			end
			if (inBlock(regReq.addr, `PWM_ADDR_DUTY_BASE)) begin
				dutySetting[regReq.addr[2:0]] <= regReq.wrData;
			end
		end
	end

	// read data stand in the cycle after the strobe only
	always_comb begin
		next_rdData = `PWM_RESET_BYTE;
		if (regReq.rdStrobe && regReq.addr == `PWM_ADDR_MODULE_STOP) begin
			next_rdData = {7'h00, moduleStop};
		end else if (rdAccess) begin
			if (inBlock(regReq.addr, `PWM_ADDR_PRESCALE_BASE)) begin
				next_rdData = prescaleSetting[regReq.addr[2:0]];
			end else if (inBlock(regReq.addr, `PWM_ADDR_DUTY_BASE)) begin
				next_rdData = dutySetting[regReq.addr[2:0]];
			end else begin
				case (regReq.addr)
					`PWM_ADDR_OUTPUT_CONTROL: next_rdData = 8'(channelOutputEnable);
					`PWM_ADDR_POLARITY: next_rdData = 8'(addedPulsePolarity);
					`PWM_ADDR_PAIR_MODE: next_rdData = 8'(pairMode);
					`PWM_ADDR_DIVISION_SELECT: next_rdData = 8'(divisionSelect);
					`PWM_ADDR_PIN_STATUS: next_rdData = 8'(pwmOut);
					default: next_rdData = `PWM_RESET_BYTE;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData <= `PWM_RESET_BYTE;
		end else begin
			rdData <= next_rdData;
		end
	end

	genvar c;
	generate
		for (c = 0; c < CHANNELS; c++) begin : gen_chan
			localparam int EVEN = c - c % 2;
			localparam int ODD = EVEN + 1;
			logic [1:0] modeField;
			logic cascaded;
			logic leader;
			logic load;
			logic [15:0] dutyValue;
			logic level;

			assign modeField = pairMode[`PWM_PAIR_FIELD_W*(c/2) +: `PWM_PAIR_FIELD_W];
			// setting 3 is prohibited and falls back to independent 8-bit channels
			assign cascaded = modeField == `PWM_PAIR_12BIT || modeField == `PWM_PAIR_16BIT;
			// in a cascaded pair the odd channel's counters and prescaler sleep
			assign leader = c % 2 == 0 || !cascaded;

			always_comb begin
				if (modeField == `PWM_PAIR_12BIT) begin
					chanMode[c] = pwm_pkg::MODE_SINGLE12;
				end else if (modeField == `PWM_PAIR_16BIT) begin
					chanMode[c] = pwm_pkg::MODE_SINGLE16;
				end else if (divisionSelect[c]) begin
					chanMode[c] = pwm_pkg::MODE_DIV8;
				end else begin
					chanMode[c] = pwm_pkg::MODE_SINGLE8;
				end
			end

			// run is the pair leader's enable; disabled channels hold counters idle
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					run[c] <= 1'b0;
				end else begin
					run[c] <= channelOutputEnable[c] && leader && !moduleStop;
				end
			end

			pwm_clock_gen u_clock_gen (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.run(run[c]),
				.prescaleSetting(prescaleSetting[c]),
				.tick(tick[c])
			);

			assign overflow[c] = tick[c] && dutyCount[c] == limitFor(chanMode[c]);

			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					dutyCount[c] <= '0;
				end else if (!run[c]) begin
					dutyCount[c] <= '0;
				end else if (overflow[c]) begin
					dutyCount[c] <= '0;
				end else if (tick[c]) begin
					dutyCount[c] <= dutyCount[c] + 16'h0001;
				end
			end

			// the odd latch of a cascaded pair follows the even channel's counter,
			// so both bytes change together
			assign load = cascaded ? (!run[EVEN] || overflow[EVEN]) : (!run[c] || overflow[c]);

			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					dutyLatch[c] <= `PWM_RESET_BYTE;
				end else if (load) begin
					dutyLatch[c] <= dutySetting[c];
				end
			end

			if (c % 2 == 0) begin : gen_value
				always_comb begin
					case (chanMode[c])
						pwm_pkg::MODE_SINGLE12: dutyValue = {4'h0, dutyLatch[ODD][`PWM_HI12_MSB:0],
							dutyLatch[c]};
						pwm_pkg::MODE_SINGLE16: dutyValue = {dutyLatch[ODD], dutyLatch[c]};
						default: dutyValue = {8'h00, dutyLatch[c]};
					endcase
				end
			end else begin : gen_value
				assign dutyValue = {8'h00, dutyLatch[c]};
			end

			pwm_pulse_div u_pulse_div (
				.position(dutyCount[c][7:0]),
				.dutyLatch(dutyLatch[c]),
				.polarity(addedPulsePolarity[c]),
				.level(divLevel[c])
			);

			// position 0 at start, so any nonzero duty begins high; in division mode only a nonzero upper nibble does
			assign level = chanMode[c] == pwm_pkg::MODE_DIV8 ? divLevel[c] :
				dutyCount[c] < dutyValue;

			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					pwmOut[c] <= 1'b0;
				end else begin
					pwmOut[c] <= run[c] && level;
				end
			end
		end
	endgenerate
endmodule

// file: inc/pwm_consts.svh
// constants for the six-channel pulse width unit: register offsets, field codes,
// counter limits and reset values. assumes an 8-bit register port.
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

// register offsets (byte addresses on the register port)
`define PWM_ADDR_PRESCALE_BASE 8'h00
`define PWM_ADDR_DUTY_BASE 8'h08
`define PWM_ADDR_OUTPUT_CONTROL 8'h10
`define PWM_ADDR_POLARITY 8'h11
`define PWM_ADDR_PAIR_MODE 8'h12
`define PWM_ADDR_DIVISION_SELECT 8'h13
`define PWM_ADDR_MODULE_STOP 8'h14
`define PWM_ADDR_PIN_STATUS 8'h15
`define PWM_ADDR_BLOCK_MASK 8'hf8

// pair mode field codes, two bits per channel pair
`define PWM_PAIR_8BIT 2'h0
`define PWM_PAIR_12BIT 2'h1
`define PWM_PAIR_16BIT 2'h2
`define PWM_PAIR_FIELD_W 2

// last duty counter value before overflow in each mode
`define PWM_LIMIT_SINGLE8 16'h00fe
`define PWM_LIMIT_SINGLE12 16'h0ffe
`define PWM_LIMIT_SINGLE16 16'hfffe
`define PWM_LIMIT_DIV8 16'h00ff

// field positions
`define PWM_HI12_MSB 3
`define PWM_DIV_SLOT_LAST 4'hf

// reset values
`define PWM_RESET_BYTE 8'h00
`define PWM_RESET_MODULE_STOP 1'b1

`endif

// file: inc/pwm_pkg.sv
// types shared by the pulse width unit and its bench.
// assumes pwm_consts.svh supplies the numeric constants.
package pwm_pkg;

	typedef enum logic [1:0] {
		MODE_SINGLE8,
		MODE_SINGLE12,
		MODE_SINGLE16,
		MODE_DIV8
	} chan_mode_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic wrStrobe;
		logic rdStrobe;
	} reg_req_s;

endpackage

// file: hdl/pwm_clock_gen.sv
// prescaler of one channel: a down counter reloaded from the prescale latch.
// assumes run is a registered level from the top module.
`timescale 1ns/1ps
`include "pwm_consts.svh"
module pwm_clock_gen (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic run,
	input wire logic [7:0] prescaleSetting,
	output logic tick
);
	logic [7:0] prescaleLatch;
	logic [7:0] genCount;

	// idle: latch follows the setting so the first period already uses it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prescaleLatch <= `PWM_RESET_BYTE;
		end else if (!run || genCount == `PWM_RESET_BYTE) begin
			prescaleLatch <= prescaleSetting;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			genCount <= `PWM_RESET_BYTE;
		end else if (!run) begin
			genCount <= prescaleSetting;
		end else if (genCount == `PWM_RESET_BYTE) begin
			// running periods count from the latch, so a setting written mid-period
			// cannot stretch or cut the tick in progress
			genCount <= prescaleLatch;
		end else begin
			genCount <= genCount - 8'h01;
		end
	end

	// one tick per n+1 clocks
	assign tick = run && genCount == `PWM_RESET_BYTE;
endmodule

// file: hdl/pwm_pulse_div.sv
// output level of one channel in pulse-division mode, from the duty counter
// position and the latched duty byte. purely combinational.
`timescale 1ns/1ps
`include "pwm_consts.svh"
module pwm_pulse_div (
	input wire logic [7:0] position,
	input wire logic [7:0] dutyLatch,
	input wire logic polarity,
	output logic level
);
	// rank of a basic pulse in the spreading order 15,7,11,3,...: the bit
	// reverse of its complement; basic pulse 0 gets rank 15 and is never used
	function automatic logic chosen(input logic [3:0] basicNum, input logic [3:0] count);
		logic [3:0] inv;
		logic [3:0] rank;
		inv = ~basicNum;
		rank = {inv[0], inv[1], inv[2], inv[3]};
		return rank < count;
	endfunction

	logic [3:0] slot;
	logic [3:0] basicNum;
	logic [3:0] nextBasic;
	logic basicHigh;
	logic addedHigh;

	assign slot = position[3:0];
	assign basicNum = position[7:4];
	assign nextBasic = basicNum + 4'h1;
	assign basicHigh = slot < dutyLatch[7:4];

	always_comb begin
		if (!polarity) begin
			// one slot high right before the rise of the chosen basic pulse, also
			// when the upper bits are zero and no rise exists
			addedHigh = slot == `PWM_DIV_SLOT_LAST && chosen(nextBasic, dutyLatch[3:0]);
		end else begin
			addedHigh = slot == dutyLatch[7:4] && chosen(basicNum, dutyLatch[3:0]);
		end
	end

	assign level = basicHigh || addedHigh;
endmodule

// file: bench/pwm_unit_properties.sv
// checker for the pulse width unit, watching the top-level ports only.
// assumes the offsets in pwm_consts.svh and a single clock domain.
`timescale 1ns/1ps
`include "pwm_consts.svh"
module pwm_unit_properties #(
	parameter int CHANNELS = 6
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire pwm_pkg::reg_req_s regReq,
	input wire logic [7:0] rdData,
	input wire logic [CHANNELS-1:0] pwmOut
);
	logic stopped;
	logic [7:0] enable;
	logic [7:0] pairMode;
	logic [7:0] duty0;
	logic [CHANNELS-1:0] enMask;
	// shadow copies follow software writes; while stopped only writes to the stop register land
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stopped <= `PWM_RESET_MODULE_STOP;
		end else if (regReq.wrStrobe && regReq.addr == `PWM_ADDR_MODULE_STOP) begin
			stopped <= regReq.wrData[0];
		end
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			enable <= `PWM_RESET_BYTE;
			pairMode <= `PWM_RESET_BYTE;
			duty0 <= `PWM_RESET_BYTE;
		end else if (regReq.wrStrobe && !stopped) begin
			if (regReq.addr == `PWM_ADDR_OUTPUT_CONTROL) enable <= regReq.wrData;
			if (regReq.addr == `PWM_ADDR_PAIR_MODE) pairMode <= regReq.wrData;
			if (regReq.addr == `PWM_ADDR_DUTY_BASE) duty0 <= regReq.wrData;
		end
	end
	assign enMask = stopped ? '0 : enable[CHANNELS-1:0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	property p_stop_read;
		regReq.rdStrobe && stopped && regReq.addr != `PWM_ADDR_MODULE_STOP |=> rdData == 8'h00;
	endproperty
	a_stop_read: assert property (p_stop_read) else $error("stopped unit returned data");
	property p_stop_back;
		regReq.rdStrobe && regReq.addr == `PWM_ADDR_MODULE_STOP |=> rdData[0] == $past(stopped);
	endproperty
	a_stop_back: assert property (p_stop_back) else $error("stop bit read back wrong");
	property p_stop_pins;
		stopped [*4] |-> pwmOut == '0;
	endproperty
	a_stop_pins: assert property (p_stop_pins) else $error("pin active while stopped");
	// pins lag the enable by up to two edges
	property p_idle_low;
		(pwmOut & ~(enMask | $past(enMask) | $past(enMask, 2) | $past(enMask, 3))) == '0;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("disabled pin driven high");
	property p_first_high;
		$rose(enMask[0]) && pairMode[1:0] == `PWM_PAIR_8BIT && duty0[7:4] != 4'h0
			|-> ##[1:3] pwmOut[0];
	endproperty
	a_first_high: assert property (p_first_high) else $error("first level not high");
	property p_odd_low;
		(pairMode[1:0] == `PWM_PAIR_12BIT || pairMode[1:0] == `PWM_PAIR_16BIT) [*4] |-> !pwmOut[1];
	endproperty
	a_odd_low: assert property (p_odd_low) else $error("odd pin of a pair driven");
	property p_rd_quiet;
		!$past(regReq.rdStrobe) |-> rdData == 8'h00;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside its cycle");
	property p_unmapped;
		regReq.rdStrobe && regReq.addr > `PWM_ADDR_PIN_STATUS |=> rdData == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	c_rise0: cover property ($rose(pwmOut[0]));
	c_wide: cover property (pairMode[1:0] == `PWM_PAIR_16BIT && pwmOut[0]);
	c_fall2: cover property ($fell(pwmOut[2]));
endmodule
bind pulse_width_unit pwm_unit_properties #(.CHANNELS(CHANNELS)) pwm_unit_properties_i (
	.core_clk(core_clk),
	.arst_n(arst_n),
	.regReq(regReq),
	.rdData(rdData),
	.pwmOut(pwmOut)
);

// file: bench/pwm_filter_model.sv
// load on one pin: an ideal integrator in place of the external low-pass filter.
// assumes one clock; clr starts a new integration window.
`timescale 1ns/1ps
module pwm_filter_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic pin,
	input wire logic clr,
	output logic [19:0] highCnt
);
	// the filter output is the mean level, so high clocks per window is enough; ripple ignored
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			highCnt <= 20'h0_0000;
		end else if (clr) begin
			highCnt <= 20'h0_0000;
		end else begin
			highCnt <= highCnt + 20'(pin);
		end
	end
endmodule

// file: bench/pulse_width_unit_tb.sv
// bench for the pulse width unit: register traffic and high time per window.
// assumes the filter model integrates the selected pin.
`timescale 1ns/1ps
`include "pwm_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pulse_width_unit_tb;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	pwm_pkg::reg_req_s regReq = '0;
	logic [7:0] rdData;
	logic [5:0] pwmOut;
	logic clr = 1'b0;
	logic measValid = 1'b0;
	logic rdPend = 1'b0;
	logic [19:0] highCnt;
	logic [19:0] measVal = '0;
	logic [19:0] expQ[$];
	logic [19:0] expV;
	int selCh = 0;
	int n_errors = 0;
	int check_count = 0;
	always #2.5 core_clk = ~core_clk;
	pulse_width_unit #(.CHANNELS(6)) pulse_width_unit_i (.core_clk(core_clk), .arst_n(arst_n),
		.regReq(regReq), .rdData(rdData), .pwmOut(pwmOut));
	pwm_filter_model pwm_filter_model_i (.core_clk(core_clk), .arst_n(arst_n),
		.pin(pwmOut[selCh]), .clr(clr), .highCnt(highCnt));
	always @(posedge core_clk) begin
		// pop once into expV: the macro names its expected value twice
		if (rdPend) begin
			expV = expQ.pop_front();
			`CHK({12'h000, rdData}, expV)
		end
		if (measValid) begin
			expV = expQ.pop_front();
			`CHK(measVal, expV)
		end
		rdPend = regReq.rdStrobe;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		regReq.addr <= a;
		regReq.wrData <= v;
		regReq.wrStrobe <= 1'b1;
		@(posedge core_clk);
		regReq.wrStrobe <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back({12'h000, e});
		regReq.addr <= a;
		regReq.rdStrobe <= 1'b1;
		@(posedge core_clk);
		regReq.rdStrobe <= 1'b0;
		@(posedge core_clk);
	endtask
	// a window of exactly one period gives the same count from any phase
	task automatic meas(input int win, input logic [19:0] e);
		expQ.push_back(e);
		repeat (8) @(posedge core_clk);
		clr <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
		repeat (win + 1) @(posedge core_clk);
		measVal <= highCnt;
		measValid <= 1'b1;
		@(posedge core_clk);
		measValid <= 1'b0;
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#(5 * 95000);
		n_errors++;
		end_of_test;
	end
	initial begin
		logic [7:0] dv;
		void'($urandom(32'hced6));
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd(`PWM_ADDR_MODULE_STOP, 8'h01);
		wr(`PWM_ADDR_DUTY_BASE, 8'h55);
		rd(`PWM_ADDR_DUTY_BASE, 8'h00);
		wr(`PWM_ADDR_MODULE_STOP, 8'h00);
		for (int i = 0; i < 22; i++) rd(8'(i), 8'h00);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00);
		for (int i = 0; i < 12; i++) begin
			dv = 8'($urandom);
			wr(8'(i), dv);
			// offsets 6 and 7 of each block have no channel behind them
			rd(8'(i), (i % 8 < 6) ? dv : 8'h00);
		end
		wr(`PWM_ADDR_PRESCALE_BASE, 8'h01);
		wr(`PWM_ADDR_DUTY_BASE, 8'h80);
		wr(`PWM_ADDR_OUTPUT_CONTROL, 8'h01);
		for (int i = 0; i < 3; i++) begin
			dv = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom_range(1, 254));
			wr(`PWM_ADDR_DUTY_BASE, dv);
			repeat (520) @(posedge core_clk);
			meas(510, 20'(int'(dv) * 2));
		end
		wr(`PWM_ADDR_PRESCALE_BASE, 8'h02);
		repeat (800) @(posedge core_clk);
		meas(765, 20'(int'(dv) * 3));
		wr(`PWM_ADDR_OUTPUT_CONTROL, 8'h00);
		meas(300, 20'h0_0000);
		selCh = 2;
		wr(`PWM_ADDR_PRESCALE_BASE + 8'h02, 8'h00);
		wr(`PWM_ADDR_DIVISION_SELECT, 8'h04);
		wr(`PWM_ADDR_OUTPUT_CONTROL, 8'h04);
		for (int k = 0; k < 16; k++) begin
			dv = {(k < 2) ? 4'h0 : 4'($urandom), 4'(k)};
			wr(`PWM_ADDR_POLARITY, 8'($urandom));
			wr(`PWM_ADDR_DUTY_BASE + 8'h02, dv);
			repeat (260) @(posedge core_clk);
			meas(256, 20'(int'(dv[7:4]) * 16 + k));
		end
		wr(`PWM_ADDR_OUTPUT_CONTROL, 8'h00);
		selCh = 0;
		wr(`PWM_ADDR_PAIR_MODE, 8'h01);
		wr(`PWM_ADDR_PRESCALE_BASE, 8'h00);
		wr(`PWM_ADDR_PRESCALE_BASE + 8'h01, 8'h07);
		wr(`PWM_ADDR_DUTY_BASE, 8'h34);
		wr(`PWM_ADDR_DUTY_BASE + 8'h01, 8'ha1);
		wr(`PWM_ADDR_OUTPUT_CONTROL, 8'h03);
		meas(4095, 20'h0_0134);
		wr(`PWM_ADDR_OUTPUT_CONTROL, 8'h00);
		wr(`PWM_ADDR_PAIR_MODE, 8'h02);
		wr(`PWM_ADDR_DUTY_BASE, 8'h10);
		wr(`PWM_ADDR_DUTY_BASE + 8'h01, 8'h01);
		wr(`PWM_ADDR_OUTPUT_CONTROL, 8'h01);
		meas(65535, 20'h0_0110);
		wr(`PWM_ADDR_MODULE_STOP, 8'h01);
		rd(`PWM_ADDR_OUTPUT_CONTROL, 8'h00);
		meas(20, 20'h0_0000);
		@(posedge core_clk);
		end_of_test;
	end
endmodule
